// ### hdl/cfg_bank_pkg.sv
// Package for the LED driver sync/PLL configuration bank.
// Assumes one 10 MHz system clock and a byte-wide register port.
package cfg_bank_pkg;

  // Register offsets
  localparam logic [7:0] ADDR_TEMP_FILT  = 8'h69;
  localparam logic [7:0] ADDR_PWRLINE    = 8'h6A;
  localparam logic [7:0] ADDR_SLOW_HIGH  = 8'h6B;
  localparam logic [7:0] ADDR_SYNC_LOW   = 8'h6C;
  localparam logic [7:0] ADDR_PLL_SEL    = 8'h6D;
  localparam logic [7:0] ADDR_SYNC_TYPE  = 8'h6E;
  localparam int         REG_COUNT       = 6;

  // Reset values
  localparam logic [7:0] RST_TEMP_FILT   = 8'h00;
  localparam logic [7:0] RST_PWRLINE     = 8'h00;
  localparam logic [7:0] RST_SLOW_HIGH   = 8'h00;
  localparam logic [7:0] RST_SYNC_LOW    = 8'h00;
  localparam logic [7:0] RST_PLL_SEL     = 8'h00;
  localparam logic [7:0] RST_SYNC_TYPE   = 8'h00;

  // Field positions
  localparam int TEMP_GAIN_LSB   = 4;
  localparam int FILT_LEN_LSB    = 0;
  localparam int TEMP_EN_BIT     = 7;
  localparam int FET_TYPE_BIT    = 6;
  localparam int SOFT_START_LSB  = 4;
  localparam int CUR_LIMIT_LSB   = 2;
  localparam int GATE_CUR_LSB    = 0;
  localparam int SYNC_EN_BIT     = 7;
  localparam int PWM_SYNC_BIT    = 6;
  localparam int CNT_RESET_BIT   = 5;
  localparam int SLOW_LOW_LSB    = 0;
  localparam int COEFF_LSB       = 6;
  localparam int DIV_SEL_BIT     = 5;
  localparam int PLL_EN_BIT      = 4;
  localparam int PREDIV_LSB      = 0;
  localparam int SYNC_TYPE_BIT   = 4;

  // Timing
  localparam int CLK_HZ          = 10_000_000;
  localparam int OSC_HZ          = 5_000_000;
  localparam int OSC_DIV         = CLK_HZ / OSC_HZ;
  localparam int MS_TIME         = 1;
  localparam int CYCLES_PER_MS   = CLK_HZ / 1000 * MS_TIME;

  typedef enum logic [1:0] {CLK_OSC_DIRECT, CLK_PLL_INTERNAL, CLK_PLL_SYNC} clk_src_t;
  typedef enum logic {SS_IDLE, SS_RAMP} ss_state_t;

  typedef struct packed {
    logic        sync_en;
    logic        pwm_sync;
    logic        cnt_reset;
    logic [12:0] slow_div;
    logic [1:0]  coeff;
    logic        fast_div;
    logic        pll_en;
    logic [3:0]  prediv;
    logic        frame_type;
  } pll_cfg_t;

endpackage : cfg_bank_pkg

// ### hdl/led_driver_sync_pll_config_bank.sv
// Configuration bank for the LED driver: temperature dimming, power-line FET,
// soft start, comparator filter and the PWM clock/sync PLL path.
// Assumes a single-cycle register port master on SYS_CLK; pins are asynchronous.
// Summary of operation
// - Comparator is filtered for 5 to 460 PWM clock cycles before use.
// - Temperature dimming gain sits in bits 7:4 at 0x69.
// - Bit 7 at 0x6A enables temperature current dimming.
// - Gate current code; pFET always, nFET only during fault recovery.
// - Soft start lasts 5, 10, 20 or 50 ms by bits 5:4.
// - Overcurrent limit code 01/10/11 gives 4, 6 or 8 A.
// - Slow divider is 0x6B as bits 12:5 and 0x6C bits 4:0.
// - Sync input is ignored unless sync enable bit is set.
// - PWM period divided by slow divider feeds the phase detector.
// - Counter reset option clears the PWM generator on sync rising edges.
// - Slow divider coefficient is 16, 32, 64 or 128.
// - Divider select 0 picks slow divider, 1 picks fast divider.
// - PLL off clocks PWM from the 5 MHz oscillator directly.
// - Sync is pre-divided by 1 to 16 from bits 3:0 when sync type is 0; type 1 takes every sync edge.
// - Sync type selects line-rate or frame-rate sync handling.
`timescale 1ns/1ps
module led_driver_sync_pll_config_bank
  import cfg_bank_pkg::*;
#(
  parameter int PWM_BITS   = 8,
  parameter int MS_CYCLES  = CYCLES_PER_MS
)(
  input  wire logic                SYS_CLK,
  input  wire logic                RST,
  input  wire logic [7:0]          ADDR,
  input  wire logic [7:0]          WDATA,
  input  wire logic                WR,
  input  wire logic                RD,
  output logic      [7:0]          RDATA,
  input  wire logic                SYNC_IN,
  input  wire logic                COMP_IN,
  input  wire logic                FAULT_RECOVERY,
  input  wire logic                SOFT_START_GO,
  output logic                     FILTERED_COMP,
  output logic      [3:0]          TEMP_GAIN,
  output logic                     TEMP_DIM_EN,
  output logic      [11:0]         GATE_CURRENT_UA,
  output logic      [3:0]          OC_LIMIT_A,
  output logic      [5:0]          SOFT_START_MS,
  output logic                     SOFT_START_BUSY,
  output logic      [12:0]         SLOW_DIV,
  output logic      [7:0]          SLOW_COEFF,
  output logic                     FAST_DIV_SEL,
  output logic      [1:0]          CLK_SOURCE,
  output logic                     SYNC_FRAME_TYPE,
  output logic                     PWM_TICK,
  output logic      [PWM_BITS-1:0] PWM_COUNT,
  output logic                     PD_UP,
  output logic                     PD_DN
);

  function automatic logic [2:0] reg_index(input logic [7:0] a);
    case (a)
      ADDR_TEMP_FILT: reg_index = 3'h0;
      ADDR_PWRLINE:   reg_index = 3'h1;
      ADDR_SLOW_HIGH: reg_index = 3'h2;
      ADDR_SYNC_LOW:  reg_index = 3'h3;
      ADDR_PLL_SEL:   reg_index = 3'h4;
      ADDR_SYNC_TYPE: reg_index = 3'h5;
      default:        reg_index = 3'h7;
    endcase
  endfunction : reg_index

  function automatic logic [8:0] filter_len(input logic [3:0] code);
    case (code)
      4'h0:    filter_len = 9'h005;
      4'h1:    filter_len = 9'h00A;
      4'h2:    filter_len = 9'h014;
      4'h3:    filter_len = 9'h028;
      4'h4:    filter_len = 9'h03C;
      4'h5:    filter_len = 9'h050;
      4'h6:    filter_len = 9'h064;
      default: filter_len = 9'((code - 4'h7) * 40 + 140);
    endcase
  endfunction : filter_len

  function automatic logic [11:0] gate_ua(input logic [1:0] code, input logic nfet);
    case ({nfet, code})
      3'h0:    gate_ua = 12'h037;
      3'h1:    gate_ua = 12'h06E;
      3'h2:    gate_ua = 12'h0DC;
      3'h3:    gate_ua = 12'h1B8;
      3'h4:    gate_ua = 12'h12C;
      3'h5:    gate_ua = 12'h1F4;
      3'h6:    gate_ua = 12'h3E8;
      default: gate_ua = 12'h898;
    endcase
  endfunction : gate_ua

  // Register file
  logic [7:0] regs [REG_COUNT];
  logic [7:0] next_regs [REG_COUNT];
  logic [7:0] next_rdata;
  logic [2:0] wr_idx;
  logic [2:0] rd_idx;

  assign wr_idx = reg_index(ADDR);
  assign rd_idx = wr_idx;

  always_comb
  begin
    next_regs = regs;
    next_rdata = 8'h00;
    if (WR && wr_idx != 3'h7)
    begin
      next_regs[wr_idx] = WDATA;
    end
    if (RD && rd_idx != 3'h7)
    begin
      next_rdata = regs[rd_idx];
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
    begin
      regs[0] <= RST_TEMP_FILT;
      regs[1] <= RST_PWRLINE;
      regs[2] <= RST_SLOW_HIGH;
      regs[3] <= RST_SYNC_LOW;
      regs[4] <= RST_PLL_SEL;
      regs[5] <= RST_SYNC_TYPE & (8'h01 << SYNC_TYPE_BIT);
      RDATA   <= 8'h00;
    end
    else
    begin
      regs[0] <= next_regs[0];
      regs[1] <= next_regs[1];
      regs[2] <= next_regs[2];
      regs[3] <= next_regs[3];
      regs[4] <= next_regs[4];
      // Only the sync type bit exists in this register
      regs[5] <= next_regs[5] & (8'h01 << SYNC_TYPE_BIT);
      RDATA   <= next_rdata;
    end
  end

  // Field extraction
  pll_cfg_t   pcfg;
  logic [3:0] filt_code;
  logic       nfet;
  logic [1:0] ss_code;
  clk_src_t   clk_src;
  logic       lock_active;

  assign pcfg.slow_div   = {regs[2], regs[3][SLOW_LOW_LSB +: 5]};
  assign pcfg.sync_en    = regs[3][SYNC_EN_BIT];
  assign pcfg.pwm_sync   = regs[3][PWM_SYNC_BIT];
  assign pcfg.cnt_reset  = regs[3][CNT_RESET_BIT];
  assign pcfg.coeff      = regs[4][COEFF_LSB +: 2];
  assign pcfg.fast_div   = regs[4][DIV_SEL_BIT];
  assign pcfg.pll_en     = regs[4][PLL_EN_BIT];
  assign pcfg.prediv     = regs[4][PREDIV_LSB +: 4];
  assign pcfg.frame_type = regs[5][SYNC_TYPE_BIT];
  assign filt_code       = regs[0][FILT_LEN_LSB +: 4];
  assign nfet            = regs[1][FET_TYPE_BIT];
  assign ss_code         = regs[1][SOFT_START_LSB +: 2];

  always_comb
  begin
    if (!pcfg.pll_en)
      clk_src = CLK_OSC_DIRECT;
    else if (pcfg.sync_en && !pcfg.fast_div)
      clk_src = CLK_PLL_SYNC;
    else
      clk_src = CLK_PLL_INTERNAL;
  end

  // slow divider loop only with sync path
  assign lock_active = (clk_src == CLK_PLL_SYNC) && pcfg.pwm_sync;

  // Pin synchronisers
  logic [3:0] pin_meta;
  logic [3:0] pin_sync;
  logic       sync_prev;
  logic       sync_edge;
  logic       comp_s;
  logic       fault_s;
  logic       go_s;
  logic       go_prev;

  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
    begin
      pin_meta  <= 4'h0;
      pin_sync  <= 4'h0;
      sync_prev <= 1'b0;
      go_prev   <= 1'b0;
    end
    else
    begin
      pin_meta  <= {SOFT_START_GO, FAULT_RECOVERY, COMP_IN, SYNC_IN};
      pin_sync  <= pin_meta;
      sync_prev <= pin_sync[0];
      go_prev   <= pin_sync[3];
    end
  end

  assign comp_s  = pin_sync[1];
  assign fault_s = pin_sync[2];
  assign go_s    = pin_sync[3];
  assign sync_edge = pcfg.sync_en && pin_sync[0] && !sync_prev;

  // PWM generator, pre-divider, feedback divider, phase detector
  logic [0:0]          osc_cnt,  next_osc_cnt;
  logic [PWM_BITS-1:0] pwm_cnt,  next_pwm_cnt;
  logic [3:0]          pre_cnt,  next_pre_cnt;
  logic [12:0]         fb_cnt,   next_fb_cnt;
  logic                pd_up,    next_pd_up;
  logic                pd_dn,    next_pd_dn;
  logic                ref_pulse;
  logic                fb_pulse;
  logic                pre_pulse;
  logic                wrap;

  assign PWM_TICK = (clk_src == CLK_OSC_DIRECT) ? (osc_cnt == 1'(OSC_DIV - 1)) : 1'b1;
  assign wrap = PWM_TICK && (pwm_cnt == {PWM_BITS{1'b1}});
  assign pre_pulse = sync_edge && (pre_cnt == pcfg.prediv);
  assign ref_pulse = lock_active && (pcfg.frame_type ? sync_edge : pre_pulse);
  // feedback pulse after slow divider periods
  assign fb_pulse = lock_active && wrap && (fb_cnt + 13'h0001 >= pcfg.slow_div);

  always_comb
  begin
    next_osc_cnt = (clk_src == CLK_OSC_DIRECT) ? osc_cnt + 1'b1 : 1'b0;
    next_pwm_cnt = pwm_cnt;
    if (pcfg.cnt_reset && sync_edge)
      next_pwm_cnt = '0;
    else if (PWM_TICK)
      next_pwm_cnt = pwm_cnt + 1'b1;
    next_pre_cnt = pre_cnt;
    if (pre_pulse)
      next_pre_cnt = 4'h0;
    else if (sync_edge)
      next_pre_cnt = pre_cnt + 4'h1;
    next_fb_cnt = fb_cnt;
    if (!lock_active || fb_pulse)
      next_fb_cnt = 13'h0000;
    else if (wrap)
      next_fb_cnt = fb_cnt + 13'h0001;
    next_pd_up = pd_up | ref_pulse;
    next_pd_dn = pd_dn | fb_pulse;
    if (!lock_active || (next_pd_up && next_pd_dn))
    begin
      next_pd_up = 1'b0;
      next_pd_dn = 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
    begin
      osc_cnt <= 1'b0;
      pwm_cnt <= '0;
      pre_cnt <= 4'h0;
      fb_cnt  <= 13'h0000;
      pd_up   <= 1'b0;
      pd_dn   <= 1'b0;
    end
    else
    begin
      osc_cnt <= next_osc_cnt;
      pwm_cnt <= next_pwm_cnt;
      pre_cnt <= next_pre_cnt;
      fb_cnt  <= next_fb_cnt;
      pd_up   <= next_pd_up;
      pd_dn   <= next_pd_dn;
    end
  end

  assign PWM_COUNT = pwm_cnt;
  assign PD_UP     = pd_up;
  assign PD_DN     = pd_dn;

  // Comparator filter and soft-start timer
  logic        comp_filt, next_comp_filt;
  logic [8:0]  filt_cnt,  next_filt_cnt;
  ss_state_t   ss_state,  next_ss_state;
  logic [15:0] cyc_cnt,   next_cyc_cnt;
  logic [5:0]  ms_cnt,    next_ms_cnt;
  logic [5:0]  ss_ms;

  always_comb
  begin
    case (ss_code)
      2'h0:    ss_ms = 6'h05;
      2'h1:    ss_ms = 6'h0A;
      2'h2:    ss_ms = 6'h14;
      default: ss_ms = 6'h32;
    endcase
  end

  always_comb
  begin
    next_comp_filt = comp_filt;
    next_filt_cnt  = filt_cnt;
    // comparator must hold for the filter length
    if (comp_s == comp_filt)
      next_filt_cnt = 9'h000;
    else if (PWM_TICK)
    begin
      if (filt_cnt + 9'h001 >= filter_len(filt_code))
      begin
        next_comp_filt = comp_s;
        next_filt_cnt  = 9'h000;
      end
      else
        next_filt_cnt = filt_cnt + 9'h001;
    end
    next_ss_state = ss_state;
    next_cyc_cnt  = cyc_cnt;
    next_ms_cnt   = ms_cnt;
    case (ss_state)
      SS_IDLE:
      begin
        next_cyc_cnt = 16'h0000;
        next_ms_cnt  = 6'h00;
        if (go_s && !go_prev)
          next_ss_state = SS_RAMP;
      end
      SS_RAMP:
      begin
        next_cyc_cnt = cyc_cnt + 16'h0001;
        if (cyc_cnt == 16'(MS_CYCLES - 1))
        begin
          next_cyc_cnt = 16'h0000;
          next_ms_cnt  = ms_cnt + 6'h01;
          if (ms_cnt + 6'h01 >= ss_ms)
            next_ss_state = SS_IDLE;
        end
      end
      default: next_ss_state = SS_IDLE;
    endcase
  end

  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
    begin
      comp_filt <= 1'b0;
      filt_cnt  <= 9'h000;
      ss_state  <= SS_IDLE;
      cyc_cnt   <= 16'h0000;
      ms_cnt    <= 6'h00;
    end
    else
    begin
      comp_filt <= next_comp_filt;
      filt_cnt  <= next_filt_cnt;
      ss_state  <= next_ss_state;
      cyc_cnt   <= next_cyc_cnt;
      ms_cnt    <= next_ms_cnt;
    end
  end

  assign FILTERED_COMP   = comp_filt;
  assign SOFT_START_BUSY = (ss_state == SS_RAMP);

  // Registered decoded outputs
  always_ff @(posedge SYS_CLK or posedge RST)
  begin
    if (RST)
    begin
      TEMP_GAIN       <= 4'h0;
      TEMP_DIM_EN     <= 1'b0;
      GATE_CURRENT_UA <= 12'h000;
      OC_LIMIT_A      <= 4'h0;
      SOFT_START_MS   <= 6'h00;
      SLOW_DIV        <= 13'h0000;
      SLOW_COEFF      <= 8'h00;
      FAST_DIV_SEL    <= 1'b0;
      CLK_SOURCE      <= 2'h0;
      SYNC_FRAME_TYPE <= 1'b0;
    end
    else
    begin
      // gain applies only when dimming enabled
      TEMP_DIM_EN <= regs[1][TEMP_EN_BIT];
      TEMP_GAIN   <= regs[1][TEMP_EN_BIT] ? regs[0][TEMP_GAIN_LSB +: 4] : 4'h0;
      // nFET current only in fault recovery
      GATE_CURRENT_UA <= (nfet && !fault_s) ? 12'h000 : gate_ua(regs[1][GATE_CUR_LSB +: 2], nfet);
      // limit in amps, code 00 off
      OC_LIMIT_A <= (regs[1][CUR_LIMIT_LSB +: 2] == 2'h0) ? 4'h0
                  : ({1'b0, regs[1][CUR_LIMIT_LSB +: 2], 1'b0} + 4'h2);
      SOFT_START_MS   <= ss_ms;
      SLOW_DIV        <= pcfg.slow_div;
      SLOW_COEFF      <= 8'h10 << pcfg.coeff;
      FAST_DIV_SEL    <= pcfg.fast_div;
      CLK_SOURCE      <= clk_src;
      SYNC_FRAME_TYPE <= pcfg.frame_type;
    end
  end

  unmapped_read_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    RD && reg_index(ADDR) == 3'h7 |=> RDATA == 8'h00) else $error("unmapped read not zero");
  reg_readback_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    WR && ADDR == ADDR_PWRLINE ##1 RD && !WR && ADDR == ADDR_PWRLINE |=> RDATA == $past(WDATA, 2))
    else $error("readback mismatch");
  sync_gate_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    !regs[3][SYNC_EN_BIT] |-> !sync_edge) else $error("sync edge while disabled");
  counter_reset_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    sync_edge && regs[3][CNT_RESET_BIT] |=> PWM_COUNT == '0) else $error("pwm not reset on sync");
  temp_dim_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    !$past(regs[1][TEMP_EN_BIT]) |-> TEMP_GAIN == 4'h0 && !TEMP_DIM_EN) else $error("dimming while disabled");
  gate_zero_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    $past(nfet) && !$past(fault_s) |-> GATE_CURRENT_UA == 12'h000) else $error("nfet gate current outside recovery");
  pd_exclusive_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    !(PD_UP && PD_DN)) else $error("phase detector both set");
  pd_idle_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    !$past(lock_active) |-> !PD_UP && !PD_DN) else $error("phase detector set while unlocked");
  direct_tick_a: assert property (@(posedge SYS_CLK) disable iff (RST)
    clk_src == CLK_OSC_DIRECT && $stable(clk_src) && PWM_TICK |=> !PWM_TICK || clk_src != CLK_OSC_DIRECT)
    else $error("direct tick too fast");

endmodule : led_driver_sync_pll_config_bank

// ### tb/led_driver_sync_pll_config_bank_tb_top.sv
// Self-checking bench for the LED driver configuration bank.
// Drives the register port and pins itself; PWM_BITS 3 and MS_CYCLES 4 keep counts short.
`timescale 1ns/1ps
module led_driver_sync_pll_config_bank_tb_top;
  import cfg_bank_pkg::*;
  logic        clk, rst, wr, rd, sync_in, comp, fault, go;
  logic [7:0]  addr, wdata, rdata, d, coeff;
  logic        f_comp, dim_en, busy, fast, frame, tick, pd_up, pd_dn;
  logic [3:0]  gain, oc;
  logic [11:0] gate;
  logic [5:0]  ss_ms;
  logic [12:0] sdiv;
  logic [1:0]  src;
  logic [2:0]  cnt;
  int          n_errors, num_checks, nt;
  int          ss_tab[4]  = '{5, 10, 20, 50};
  int          oc_tab[4]  = '{0, 4, 6, 8};
  int          p_tab[4]   = '{55, 110, 220, 440};
  int          n_tab[4]   = '{300, 500, 1000, 2200};
  int          f_code[4]  = '{0, 1, 2, 15};
  int          f_len[4]   = '{5, 10, 20, 460};

  led_driver_sync_pll_config_bank #(.PWM_BITS(3), .MS_CYCLES(4)) DUT (
    .SYS_CLK(clk), .RST(rst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
    .SYNC_IN(sync_in), .COMP_IN(comp), .FAULT_RECOVERY(fault), .SOFT_START_GO(go),
    .FILTERED_COMP(f_comp), .TEMP_GAIN(gain), .TEMP_DIM_EN(dim_en), .GATE_CURRENT_UA(gate),
    .OC_LIMIT_A(oc), .SOFT_START_MS(ss_ms), .SOFT_START_BUSY(busy), .SLOW_DIV(sdiv),
    .SLOW_COEFF(coeff), .FAST_DIV_SEL(fast), .CLK_SOURCE(src), .SYNC_FRAME_TYPE(frame),
    .PWM_TICK(tick), .PWM_COUNT(cnt), .PD_UP(pd_up), .PD_DN(pd_dn));

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] v);
    addr  <= a;
    wdata <= v;
    wr    <= 1'b1;
    cyc(1);
    wr    <= 1'b0;
    cyc(1);
  endtask : reg_wr

  // Read data stand only in the cycle after the strobe
  task automatic reg_rd(input logic [7:0] a);
    addr <= a;
    rd   <= 1'b1;
    cyc(1);
    rd   <= 1'b0;
    d    = rdata;
    cyc(1);
    chk("rdata idle", 16'h0, 16'(rdata));
  endtask : reg_rd

  task automatic do_reset(input int n);
    rst <= 1'b1;
    cyc(n);
    rst <= 1'b0;
    cyc(1);
  endtask : do_reset

  task automatic pulse(input int n);
    repeat (n)
    begin
      sync_in <= 1'b1;
      cyc(4);
      sync_in <= 1'b0;
      cyc(4);
    end
  endtask : pulse

  // Feedback path held off by the largest slow divider
  task automatic pd_run(input logic [7:0] c, input logic [7:0] p, input logic [7:0] t, input int n,
                        input logic e);
    do_reset(2);
    reg_wr(8'h6B, 8'hFF);
    reg_wr(8'h6C, c);
    reg_wr(8'h6D, p);
    reg_wr(8'h6E, t);
    pulse(n);
    chk("pd_up", 16'(e), 16'(pd_up));
  endtask : pd_run

  // Sync rises when the count is 1, so a natural wrap cannot show 0 within 6 cycles
  task automatic cr_run(input logic [7:0] c, input logic e);
    logic seen;
    do_reset(2);
    reg_wr(8'h6D, 8'h10);
    reg_wr(8'h6C, c);
    for (int k = 0; k < 40 && cnt !== 3'h1; k++) cyc(1);
    sync_in <= 1'b1;
    seen = 1'b0;
    repeat (6)
    begin
      cyc(1);
      if (cnt === 3'h0) seen = 1'b1;
    end
    sync_in <= 1'b0;
    cyc(4);
    chk("count reset", 16'(e), 16'(seen));
  endtask : cr_run

  task automatic end_sim;
    $display("checks %0d mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_sim

  initial
  begin
    #6_000_000;
    n_errors++;
    $display("BAD watchdog expected finish seen timeout");
    end_sim();
  end

  initial
  begin
    {rst, wr, rd, sync_in, comp, fault, go} = 7'h40;
    addr = 8'h00;
    wdata = 8'h00;
    n_errors = 0;
    num_checks = 0;
    do_reset(20);
    for (int a = 8'h69; a <= 8'h6E; a++)
    begin
      reg_rd(8'(a));
      chk("reset value", 16'h0, 16'(d));
      reg_wr(8'(a), 8'(a) ^ 8'hC3);
    end
    for (int a = 8'h69; a <= 8'h6D; a++)
    begin
      reg_rd(8'(a));
      chk("readback", 16'(8'(a) ^ 8'hC3), 16'(d));
    end
    reg_wr(8'h6E, 8'hFF);
    reg_rd(8'h6E);
    chk("sync type reg", 16'h10, 16'(d));
    chk("frame type", 16'h1, 16'(frame));
    reg_wr(8'h70, 8'hFF);
    reg_rd(8'h70);
    chk("unmapped", 16'h0, 16'(d));
    reg_rd(8'h68);
    chk("unmapped", 16'h0, 16'(d));
    // Read straight after write, no gap
    addr  <= 8'h6A;
    wdata <= 8'h5C;
    wr    <= 1'b1;
    cyc(1);
    wr    <= 1'b0;
    rd    <= 1'b1;
    cyc(1);
    rd    <= 1'b0;
    chk("wr then rd", 16'h5C, 16'(rdata));
    cyc(1);
    $display("test registers done");

    reg_wr(8'h69, 8'hA3);
    reg_wr(8'h6A, 8'h00);
    chk("temp gain off", 16'h0, 16'(gain));
    chk("temp en", 16'h0, 16'(dim_en));
    reg_wr(8'h6A, 8'h80);
    chk("temp gain", 16'hA, 16'(gain));
    chk("temp en", 16'h1, 16'(dim_en));
    for (int c = 0; c < 4; c++)
    begin
      reg_wr(8'h6A, 8'(c * 21));
      chk("soft ms", 16'(ss_tab[c]), 16'(ss_ms));
      chk("oc limit", 16'(oc_tab[c]), 16'(oc));
      chk("gate pfet", 16'(p_tab[c]), 16'(gate));
      reg_wr(8'h6A, 8'(c * 21) | 8'h40);
      chk("gate nfet idle", 16'h0, 16'(gate));
      fault <= 1'b1;
      cyc(5);
      chk("gate nfet fault", 16'(n_tab[c]), 16'(gate));
      fault <= 1'b0;
      cyc(5);
    end
    reg_wr(8'h6B, 8'hB5);
    reg_wr(8'h6C, 8'h0A);
    chk("slow div", 16'({8'hB5, 5'h0A}), 16'(sdiv));
    for (int c = 0; c < 4; c++)
    begin
      reg_wr(8'h6D, {2'(c), 6'h30});
      chk("coeff", 16'(16 << c), 16'(coeff));
      chk("fast sel", 16'h1, 16'(fast));
      chk("clk src pll", 16'h1, 16'(src));
    end
    reg_wr(8'h6D, 8'h00);
    chk("fast sel", 16'h0, 16'(fast));
    chk("clk src osc", 16'h0, 16'(src));
    nt = 0;
    repeat (8)
    begin
      cyc(1);
      nt += int'(tick);
    end
    chk("osc ticks", 16'h4, 16'(nt));
    $display("test fields done");

    do_reset(2);
    reg_wr(8'h6D, 8'h10);
    for (int c = 0; c < 4; c++)
    begin
      reg_wr(8'h69, 8'(f_code[c]));
      comp <= 1'b1;
      cyc(f_len[c] - 2);
      chk("filter early", 16'h0, 16'(f_comp));
      cyc(8);
      chk("filter set", 16'h1, 16'(f_comp));
      comp <= 1'b0;
      cyc(f_len[c] + 8);
      chk("filter clear", 16'h0, 16'(f_comp));
    end
    $display("test filter done");

    for (int c = 0; c < 4; c++)
    begin
      reg_wr(8'h6A, 8'(c << 4));
      go <= 1'b1;
      cyc(5);
      chk("ss busy start", 16'h1, 16'(busy));
      cyc(ss_tab[c] * 4 - 4);
      chk("ss busy end", 16'h1, 16'(busy));
      cyc(6);
      chk("ss done", 16'h0, 16'(busy));
      go <= 1'b0;
      cyc(4);
    end
    $display("test soft start done");

    cr_run(8'hA0, 1'b1);
    cr_run(8'h20, 1'b0);
    cr_run(8'h80, 1'b0);
    $display("test counter reset done");

    pd_run(8'hDF, 8'h12, 8'h00, 2, 1'b0);
    pd_run(8'hDF, 8'h12, 8'h00, 3, 1'b1);
    pd_run(8'h9F, 8'h12, 8'h00, 3, 1'b0);
    pd_run(8'h5F, 8'h12, 8'h00, 3, 1'b0);
    pd_run(8'hDF, 8'h32, 8'h00, 3, 1'b0);
    pd_run(8'hDF, 8'h1F, 8'h10, 1, 1'b1);
    // Slow divider of one: every wrap is a feedback pulse
    do_reset(2);
    reg_wr(8'h6C, 8'hC1);
    reg_wr(8'h6D, 8'h10);
    cyc(10);
    chk("clk src sync", 16'h2, 16'(src));
    chk("pd_dn", 16'h1, 16'(pd_dn));
    chk("pd_up idle", 16'h0, 16'(pd_up));
    $display("test phase detector done");
    end_sim();
  end
endmodule : led_driver_sync_pll_config_bank_tb_top
